// ===== tb/jacs_probe.sv
// Probe model: drives the test clock and waits for its echo
`default_nettype none
module jacs_probe
(
  // Control and echo
  input  wire logic            run_in,
  input  wire logic            echo_in,
  // Pins to the target
  output jacs_pkg::jacs_pins_t pins_out
);
  timeunit 1ns / 1ps;
  // ==========
  // Toggle only once the echo matches; stop with the clock low
  initial pins_out = 3'h0;
  always
  begin
    wait ((run_in || pins_out.test_clock) && echo_in == pins_out.test_clock);
    #83 pins_out.test_clock = ~pins_out.test_clock;
    if (!pins_out.test_clock) pins_out[1:0] = pins_out[1:0] + 2'h1;
  end
endmodule : jacs_probe
`default_nettype wire

// ===== tb/jacs_properties.sv
// Checker for the adaptive test-clock synchroniser
`default_nettype none
module jacs_props
(
  // Clock, reset and probe pins
  input wire logic                    clk_sys_in,
  input wire logic                    reset_in,
  input wire jacs_pkg::jacs_pins_t    pins_in,
  // Outputs and test logic side
  input wire logic                    returned_test_clock_out,
  input wire logic                    test_data_out,
  input wire logic                    test_data_oe_out,
  input wire logic                    shift_data_in,
  input wire logic                    shift_active_in,
  input wire jacs_pkg::jacs_strobes_t strobes_out
);
  timeunit 1ns / 1ps;
  // ==========
  // Properties
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (reset_in);
  wire logic r = strobes_out.rise;
  wire logic f = strobes_out.fall;
  wire logic q = returned_test_clock_out;
  strobe_pulse_a: assert property ((r || f) |=> !r && !f)
    else $error("strobe too long");
  pin_edge_a: assert property ($rose(pins_in.test_clock) |-> ##[2:3] r)
    else $error("rise strobe missing");
  echo_rise_a: assert property (r |=> q) else $error("echo not high");
  echo_fall_a: assert property (f |=> !q) else $error("echo not low");
  echo_hold_a: assert property (!r && !f |=> $stable(q))
    else $error("echo moved");
  echo_lag_a: assert property ($rose(q) |-> $past(pins_in.test_clock, 3))
    else $error("echo early");
  data_load_a: assert property (f |=> {test_data_oe_out, test_data_out} ==
    $past({shift_active_in, shift_data_in})) else $error("data not loaded");
  data_hold_a: assert property (!f |=> $stable(test_data_out))
    else $error("data moved");
  reset_clear_a: assert property ($fell(reset_in) |-> !q && !r && !f)
    else $error("not idle");
endmodule : jacs_props
bind jacs_top jacs_props i_props (.clk_sys_in, .reset_in, .pins_in,
  .returned_test_clock_out, .test_data_out, .test_data_oe_out,
  .shift_data_in, .shift_active_in, .strobes_out);
`default_nettype wire

// ===== tb/jacs_top_tb.sv
// Testbench for the adaptive test-clock synchroniser
`default_nettype none
module jacs_top_tb;
  timeunit 1ns / 1ps;
  import jacs_pkg::*;
  // ==========
  // Signals, clock, models
  logic clk_sys_in = 1'b0;
  logic reset_in = 1'b1;
  logic run = 1'b0;
  logic sa = 1'b0;
  logic sd = 1'b0;
  logic q, td, oe;
  jacs_pins_t pins;
  jacs_strobes_t st;
  int error_cnt = 0;
  int cmp_count = 0;
  int ticks = 0;
  int edges = 0;
  int rises = 0;
  always #5 clk_sys_in = ~clk_sys_in;
  jacs_top i_dut (.clk_sys_in, .reset_in, .pins_in(pins), .strobes_out(st),
    .returned_test_clock_out(q), .test_data_out(td), .test_data_oe_out(oe),
    .shift_data_in(sd), .shift_active_in(sa));
  jacs_probe i_probe (.run_in(run), .echo_in(q), .pins_out(pins));
  // Test logic side, edge counters and timeout
  always @(negedge clk_sys_in) {sa, sd} <= {sa, sd} + 2'h1;
  always @(posedge pins.test_clock) edges++;
  // Strobes are sampled mid-cycle, where they have settled
  always @(negedge clk_sys_in) rises += st.rise;
  // Ceiling of 3000 system cycles on the whole run; past it the test ends failed
  always @(posedge clk_sys_in)
  begin
    if (++ticks > 3000)
    begin
      error_cnt++;
      test_done();
    end
  end
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("[FAIL] %0t got %h want %h", $time, seen, exp);
    end
  endtask : check
  task automatic t_data;
    logic [1:0] exp;
    run = 1'b1;
    repeat (8)
    begin
      @(posedge st.fall);
      @(negedge clk_sys_in);
      check({6'h0, st.mode_select, st.data_in}, {6'h0, pins[1:0] - 2'h1});
      #1;
      exp = {sa, sd};
      @(negedge clk_sys_in);
      check({6'h0, oe, td}, {6'h0, exp});
    end
    run = 1'b0;
  endtask : t_data
  task automatic t_run;
    run = 1'b1;
    repeat (40) @(posedge pins.test_clock);
    run = 1'b0;
    repeat (30) @(negedge clk_sys_in);
    check(8'(rises), 8'(edges));
    check({7'h0, q}, {7'h0, pins.test_clock});
  endtask : t_run
  task automatic test_done;
    $display("errors %0d compares %0d", error_cnt, cmp_count);
    if (error_cnt == 0 && cmp_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : test_done
  initial
  begin
    repeat (3) @(negedge clk_sys_in);
    reset_in = 1'b0;
    @(negedge clk_sys_in);
    check({3'h0, q, st}, 8'h00);
    t_data();
    t_run();
    test_done();
  end
endmodule : jacs_top_tb
`default_nettype wire

// ===== verilog/jacs_pkg.sv
// Package of constants and carrier types for the adaptive test-clock sync
`default_nettype none
package jacs_pkg;
  // ==========================================================
  // Reset values and sizes
  localparam int unsigned SYNC_STAGES     = 2;
  localparam logic        IDLE_LEVEL      = 1'b0;
  localparam logic [1:0]  SYNC_RESET      = 2'h0;

  // Test port pins arriving from the probe
  typedef struct packed {
    logic test_clock;
    logic test_mode_select;
    logic test_data_in;
  } jacs_pins_t;

  // Strobes handed to the enabled test logic
  typedef struct packed {
    logic rise;
    logic fall;
    logic mode_select;
    logic data_in;
  } jacs_strobes_t;
endpackage : jacs_pkg
`default_nettype wire

// ===== verilog/jacs_sync2.sv
// Two-stage level synchroniser on the single system clock edge
`default_nettype none
module jacs_sync2
(
  // Clock and reset
  input  wire logic clk_sys_in,
  input  wire logic reset_in,
  // Level in and out
  input  wire logic async_in,
  output logic      sync_out
);
  import jacs_pkg::*;

  logic [SYNC_STAGES-1:0] stage;

  // ==========================================================
  // Shift chain; only the last stage is read outside
  always_ff @(posedge clk_sys_in or posedge reset_in)
  begin
    if (reset_in)
      stage <= SYNC_RESET; // R10
    else
      stage <= {stage[SYNC_STAGES-2:0], async_in}; // R9 R5
  end

  assign sync_out = stage[SYNC_STAGES-1];
endmodule : jacs_sync2
`default_nettype wire

// ===== verilog/jacs_top.sv
// Adaptive test-clock synchroniser: edge strobes, returned clock, data out
// Functional notes
// R1: The probe drives one test-clock transition and waits for the echo.
// R2: A probe seeing returned-clock pulses enables adaptive clocking.
// R3: Probe timeouts cannot scale, so a very slow target may time out.
// R4: Test-clock events become enable pulses; no flop uses the test clock.
// R5: Every flop here runs on the rising edge of the system clock.
// R6: Separate rise and fall strobes, each one system cycle per edge.
// R7: Returned clock and data output change only on their edge strobes.
// R8: The returned clock lags the test clock so no event is missed.
// R9: The test clock passes two synchroniser stages before use.
// R10: Reset clears stages, history, returned clock and strobes to low.
// R11: Data output updates on the fall strobe, inputs sample on rise.
`default_nettype none
module jacs_top
(
  // Clock and reset
  input  wire logic                   clk_sys_in,
  input  wire logic                   reset_in,
  // Probe-side pins
  input  wire jacs_pkg::jacs_pins_t   pins_in,
  output logic                        returned_test_clock_out,
  output logic                        test_data_out,
  output logic                        test_data_oe_out,
  // Test logic side
  input  wire logic                   shift_data_in,
  input  wire logic                   shift_active_in,
  output jacs_pkg::jacs_strobes_t     strobes_out
);
  import jacs_pkg::*;

  logic tck_sync;
  logic tms_sync;
  logic tdi_sync;
  logic tck_last;
  logic test_clock_rise_strobe;
  logic test_clock_fall_strobe;
  logic tms_held;
  logic tdi_held;

  // ==========================================================
  // Synchronisers for the probe pins
  jacs_sync2 u_sync_tck
  (
    .clk_sys_in (clk_sys_in),
    .reset_in   (reset_in),
    .async_in   (pins_in.test_clock),
    .sync_out   (tck_sync)
  ); // R9 R4
  jacs_sync2 u_sync_tms
  (
    .clk_sys_in (clk_sys_in),
    .reset_in   (reset_in),
    .async_in   (pins_in.test_mode_select),
    .sync_out   (tms_sync)
  );
  jacs_sync2 u_sync_tdi
  (
    .clk_sys_in (clk_sys_in),
    .reset_in   (reset_in),
    .async_in   (pins_in.test_data_in),
    .sync_out   (tdi_sync)
  );

  // ==========================================================
  // Edge history of the synchronised test clock
  always_ff @(posedge clk_sys_in or posedge reset_in)
  begin
    if (reset_in)
      tck_last <= IDLE_LEVEL; // R10
    else
      tck_last <= tck_sync; // R5
  end

  // One-cycle strobes per detected edge
  assign test_clock_rise_strobe = tck_sync & ~tck_last;  // R6 R4
  assign test_clock_fall_strobe = ~tck_sync & tck_last;  // R6

  // ==========================================================
  // Returned clock echoes each edge only after detection
  always_ff @(posedge clk_sys_in or posedge reset_in)
  begin
    if (reset_in)
      returned_test_clock_out <= IDLE_LEVEL; // R10
    else if (test_clock_rise_strobe)
      returned_test_clock_out <= 1'b1; // R7 R8
    else if (test_clock_fall_strobe)
      returned_test_clock_out <= 1'b0; // R7 R8
  end

  // Inputs captured on the rising strobe
  always_ff @(posedge clk_sys_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      tms_held <= IDLE_LEVEL;
      tdi_held <= IDLE_LEVEL;
    end
    else if (test_clock_rise_strobe)
    begin
      tms_held <= tms_sync; // R11
      tdi_held <= tdi_sync; // R11
    end
  end

  // Data output and its enable move on the falling strobe
  always_ff @(posedge clk_sys_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      test_data_out    <= IDLE_LEVEL;
      test_data_oe_out <= IDLE_LEVEL;
    end
    else if (test_clock_fall_strobe)
    begin
      test_data_out    <= shift_data_in;   // R7 R11
      test_data_oe_out <= shift_active_in; // R7
    end
  end

  // ==========================================================
  // Strobes and captured inputs to the test logic
  always_comb
  begin
    strobes_out.rise        = test_clock_rise_strobe;
    strobes_out.fall        = test_clock_fall_strobe;
    strobes_out.mode_select = tms_held;
    strobes_out.data_in     = tdi_held;
  end
endmodule : jacs_top
`default_nettype wire
